// >>> src/card16_dma_pkg.sv
package card16_dma_pkg;
  // ---------------------------------------------------------------
  // configuration space offsets and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_SYS_CTRL = 8'h80;
  localparam logic [7:0] CFG_SOCK_DMA0 = 8'h94;
  localparam logic [7:0] CFG_SOCK_DMA1 = 8'h98;
  localparam logic [31:0] SYS_CTRL_RESET = 32'h0000_0008;
  localparam logic [31:0] SOCK_DMA0_RESET = 32'h0000_0000;
  localparam logic [31:0] SOCK_DMA1_RESET = 32'h0000_0000;
  localparam int SYS_GLOBAL_EN_BIT = 3;
  localparam int SYS_SLOT_EN_BIT = 19;
  localparam int SYS_CHAN_LSB = 16;
  localparam int D0_ENABLE_BIT = 0;
  localparam int D0_PIN_LSB = 1;
  localparam int D1_WORD_BIT = 0;
  localparam int D1_BASE_LSB = 4;
  localparam logic [1:0] PIN_SPEAKER = 2'h0;
  localparam logic [1:0] PIN_IO_WIDTH = 2'h1;
  localparam logic [1:0] PIN_INPUT_ACK = 2'h2;
  // ---------------------------------------------------------------
  // slave register offsets within the 16-byte window
  // ---------------------------------------------------------------
  localparam logic [3:0] DMA_ADDR = 4'h0;
  localparam logic [3:0] DMA_COUNT = 4'h4;
  localparam logic [3:0] DMA_STATUS = 4'h8;
  localparam logic [3:0] DMA_MASK = 4'hc;
  localparam int STAT_TC_BIT = 0;
  localparam int STAT_REQ_BIT = 4;
  localparam int CMD_DISABLE_BIT = 2;
  localparam int MODE_DIR_LSB = 2;
  localparam logic [1:0] MODE_TO_MEM = 2'h1;
  localparam logic [1:0] MODE_TO_CARD = 2'h2;
  localparam logic MASK_RESET = 1'b1;
  // ---------------------------------------------------------------
  // centralized scheme
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_NORMAL = 16'h0000;
  localparam logic [15:0] PC_NORMAL_TC = 16'h0004;
  localparam logic [15:0] PC_VERIFY = 16'h00c0;
  localparam logic [15:0] PC_VERIFY_TC = 16'h00c4;
  localparam logic [2:0] CHAN_UNUSED = 3'h4;
  localparam logic [2:0] SER_FRAME_BITS = 3'h5;
  localparam logic [2:0] GNT_FRAME_BITS = 3'h4;
  typedef enum logic [2:0] {ST_IDLE, ST_CARD, ST_REQ, ST_BUS, ST_PCPCI} xfer_state_t;
endpackage

// >>> src/bit_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;
  // ---------------------------------------------------------------
  // two-stage synchroniser
  // ---------------------------------------------------------------
  // resets high: every synced pin here is active low and idles high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta <= '1;
      q_out <= '1;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> src/card16_dma_slave.sv
// Functional notes
// - socket config 0 enables distributed DMA and picks request pin of three
// - socket config 1 holds slave register I/O base and byte/word size
// - offset 00h reads current address/page, writes base; 04h likewise count
// - 08h reads status, takes mode/request/command; 0Ch multichannel, mask, clear
// - legacy bits without meaning here are read-only and do nothing
// - reserved slave locations read zero and ignore writes
// - card-to-memory: take card data, request bus, single memory write, repeat
// - memory-to-card: on card request, get bus, read memory, pass to card
// - slave registers stay accessible over I/O while a distributed transfer runs
// - channel reset mid-transfer raises terminal count, ends card cycle, sets status
// - demand mode; acknowledge held until request withdrawn or terminal count
// - terminal count on OE pin to memory, WE pin to card; ack on attribute
// - centralized: serial request on legacy request line, chipset grants serially
// - per-slot centralized enable at system control bit 19, cleared at reset
// - system control bit 3 is the global centralized enable
// - channel field picks 0..7; 0-3 byte, 4 unused, 5-7 word
// - centralized width follows channel; slave registers take no part
// - centralized mode still uses socket config 0 request pin choice
// - granted with request: decode 00h, 04h I/O cycles and C0h, C4h reads
`timescale 1ns/100ps
`default_nettype none
module card16_dma_slave (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic cfg_ack_out,
  output logic [31:0] cfg_rdata_out,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [3:0] io_be_in,
  input wire logic [31:0] io_wdata_in,
  output logic io_ack_out,
  output logic io_miss_out,
  output logic [31:0] io_rdata_out,
  output logic pci_req_n_out,
  input wire logic pci_gnt_n_in,
  input wire logic pci_idle_in,
  output logic mst_start_out,
  output logic mst_write_out,
  output logic [31:0] mst_addr_out,
  output logic [15:0] mst_wdata_out,
  input wire logic mst_done_in,
  input wire logic [15:0] mst_rdata_in,
  input wire logic card_speaker_pin_n_in,
  input wire logic card_io_width_pin_n_in,
  input wire logic card_input_ack_pin_n_in,
  output logic card_cycle_out,
  output logic card_write_out,
  output logic card_word_out,
  output logic [15:0] card_wdata_out,
  input wire logic card_done_in,
  input wire logic [15:0] card_rdata_in,
  output logic card_dma_ack_out,
  output logic card_oe_tc_out,
  output logic card_we_tc_out,
  output logic legacy_request_line_out,
  input wire logic legacy_grant_line_n_in
);
  import card16_dma_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pins_s;
  bit_sync2 #(.WIDTH(4)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({legacy_grant_line_n_in, card_input_ack_pin_n_in,
           card_io_width_pin_n_in, card_speaker_pin_n_in}),
    .q_out(pins_s)
  );

  logic [31:0] sys_ctrl, sock_dma0, sock_dma1;
  logic [31:0] next_sys_ctrl, next_sock_dma0, next_sock_dma1, next_cfg_rdata;
  logic next_cfg_ack;
  logic card_dma_request, distributed_dma_en, word_mode, slot_on, chan_word, granted, pc_tc_done;
  logic [2:0] chan;

  // request pin choice is shared by both schemes
  always_comb begin
    case (sock_dma0[D0_PIN_LSB +: 2])
      PIN_SPEAKER: card_dma_request = !pins_s[0];
      PIN_IO_WIDTH: card_dma_request = !pins_s[1];
      PIN_INPUT_ACK: card_dma_request = !pins_s[2];
      default: card_dma_request = 1'b0;
    endcase
  end
  assign distributed_dma_en = sock_dma0[D0_ENABLE_BIT];
  assign word_mode = sock_dma1[D1_WORD_BIT];
  assign chan = sys_ctrl[SYS_CHAN_LSB +: 3];
  assign chan_word = chan[2];
  assign slot_on = sys_ctrl[SYS_SLOT_EN_BIT] && sys_ctrl[SYS_GLOBAL_EN_BIT];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_comb begin
    next_sys_ctrl = sys_ctrl;
    next_sock_dma0 = sock_dma0;
    next_sock_dma1 = sock_dma1;
    next_cfg_ack = cfg_rd_in || cfg_wr_in;
    next_cfg_rdata = 32'h0000_0000;
    case (cfg_addr_in)
      CFG_SYS_CTRL: begin
        next_cfg_rdata = sys_ctrl;
        if (cfg_wr_in) next_sys_ctrl = cfg_wdata_in;
      end
      CFG_SOCK_DMA0: begin
        next_cfg_rdata = sock_dma0;
        if (cfg_wr_in) next_sock_dma0 = cfg_wdata_in;
      end
      CFG_SOCK_DMA1: begin
        next_cfg_rdata = sock_dma1;
        if (cfg_wr_in) next_sock_dma1 = cfg_wdata_in;
      end
      default: next_cfg_rdata = 32'h0000_0000;
    endcase
  end

  // bit 19 clears and bit 3 sets at reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sys_ctrl <= SYS_CTRL_RESET;
      sock_dma0 <= SOCK_DMA0_RESET;
      sock_dma1 <= SOCK_DMA1_RESET;
      cfg_ack_out <= 1'b0;
      cfg_rdata_out <= 32'h0000_0000;
    end else begin
      sys_ctrl <= next_sys_ctrl;
      sock_dma0 <= next_sock_dma0;
      sock_dma1 <= next_sock_dma1;
      cfg_ack_out <= next_cfg_ack;
      cfg_rdata_out <= next_cfg_rdata;
    end
  end

  // ---------------------------------------------------------------
  // serialized request and grant
  // ---------------------------------------------------------------
  logic [2:0] ser_cnt, gr_cnt, next_ser_cnt, next_gr_cnt;
  logic [4:0] ser_shift, next_ser_shift;
  logic [3:0] gr_shift, next_gr_shift;
  logic sent_req, next_sent_req, next_line, next_granted, cen_req;
  assign cen_req = slot_on && card_dma_request && (chan != CHAN_UNUSED);

  // frame: start 0, request state, channel lsb first; resent on each change
  always_comb begin
    next_ser_cnt = ser_cnt;
    next_ser_shift = ser_shift;
    next_sent_req = sent_req;
    next_line = 1'b1;
    next_gr_cnt = gr_cnt;
    next_gr_shift = gr_shift;
    next_granted = granted;
    if (ser_cnt != 3'h0) begin
      next_line = ser_shift[0];
      next_ser_shift = {1'b1, ser_shift[4:1]};
      next_ser_cnt = ser_cnt - 3'h1;
    end else if (cen_req != sent_req) begin
      next_line = 1'b0;
      next_ser_shift = {1'b1, chan, cen_req};
      next_ser_cnt = SER_FRAME_BITS - 3'h1;
      next_sent_req = cen_req;
    end
    // grant frame: start 0, valid, channel lsb first
    if (gr_cnt != 3'h0) begin
      next_gr_shift = {pins_s[3], gr_shift[3:1]};
      next_gr_cnt = gr_cnt - 3'h1;
      if (gr_cnt == 3'h1) begin
        next_granted = pins_s[3] == chan[2] && gr_shift[3:2] == chan[1:0] &&
                       gr_shift[1] && slot_on;
      end
    end else if (!pins_s[3]) begin
      next_gr_cnt = GNT_FRAME_BITS;
    end
    if (pc_tc_done || !slot_on) next_granted = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ser_cnt <= 3'h0;
      ser_shift <= 5'h1f;
      sent_req <= 1'b0;
      legacy_request_line_out <= 1'b1;
      gr_cnt <= 3'h0;
      gr_shift <= 4'h0;
      granted <= 1'b0;
    end else begin
      ser_cnt <= next_ser_cnt;
      ser_shift <= next_ser_shift;
      sent_req <= next_sent_req;
      legacy_request_line_out <= next_line;
      gr_cnt <= next_gr_cnt;
      gr_shift <= next_gr_shift;
      granted <= next_granted;
    end
  end

  // ---------------------------------------------------------------
  // transfer engine, slave registers and card port
  // ---------------------------------------------------------------
  xfer_state_t state, next_state;
  logic [31:0] base_addr, cur_addr, next_base_addr, next_cur_addr;
  logic [15:0] base_count, cur_count, next_base_count, next_cur_count, hold, next_hold;
  logic [1:0] mode, next_mode;
  logic cmd_dis, mask, status_tc, pc_tc, to_mem, go, distributed_dma_hit, pc_hit, mclr, io_req;
  logic next_cmd_dis, next_mask, next_status_tc, next_pc_tc, next_pc_tc_done, done_xfer;
  logic next_io_ack, next_io_miss, next_req_n, next_start, next_mwrite;
  logic next_cyc, next_cwrite, next_cword, next_card_dma_ack, next_oe_tc, next_we_tc;
  logic [31:0] next_io_rdata;
  logic [15:0] next_cwdata;

  assign to_mem = mode == MODE_TO_MEM;
  assign io_req = io_rd_in || io_wr_in;
  assign distributed_dma_hit = distributed_dma_en && io_addr_in[15:4] == sock_dma1[D1_BASE_LSB +: 12];
  assign pc_hit = granted && card_dma_request && state == ST_IDLE &&
                  (io_addr_in == PC_NORMAL || io_addr_in == PC_NORMAL_TC ||
                   (io_rd_in && (io_addr_in == PC_VERIFY || io_addr_in == PC_VERIFY_TC)));
  assign mclr = io_wr_in && !pc_hit && distributed_dma_hit && io_addr_in[3:0] == DMA_MASK && io_be_in[1];
  assign go = distributed_dma_en && !mask && !cmd_dis && card_dma_request &&
              (mode == MODE_TO_MEM || mode == MODE_TO_CARD);

  always_comb begin
    next_state = state;
    next_base_addr = base_addr;
    next_cur_addr = cur_addr;
    next_base_count = base_count;
    next_cur_count = cur_count;
    next_hold = hold;
    next_mode = mode;
    next_cmd_dis = cmd_dis;
    next_mask = mask;
    next_status_tc = status_tc;
    next_pc_tc = pc_tc;
    next_pc_tc_done = 1'b0;
    next_io_ack = 1'b0;
    next_io_miss = 1'b0;
    next_io_rdata = io_rdata_out;
    next_req_n = pci_req_n_out;
    next_start = 1'b0;
    next_mwrite = mst_write_out;
    next_cyc = card_cycle_out;
    next_cwrite = card_write_out;
    next_cword = card_word_out;
    next_cwdata = card_wdata_out;
    next_card_dma_ack = card_dma_ack_out;
    next_oe_tc = card_oe_tc_out;
    next_we_tc = card_we_tc_out;
    done_xfer = 1'b0;
    // reading status clears terminal count; a set below still wins
    if (io_rd_in && !pc_hit && distributed_dma_hit && io_addr_in[3:0] == DMA_STATUS) next_status_tc = 1'b0;
    case (state)
      ST_IDLE: begin
        next_card_dma_ack = go;
        if (go && to_mem) begin
          next_state = ST_CARD;
          next_cyc = 1'b1;
          next_cwrite = 1'b0;
          next_cword = word_mode;
          next_oe_tc = cur_count == 16'h0000;
        end else if (go) begin
          next_state = ST_REQ;
          next_req_n = 1'b0;
        end
      end
      ST_CARD: if (card_done_in) begin
        next_cyc = 1'b0;
        next_oe_tc = 1'b0;
        next_we_tc = 1'b0;
        if (to_mem) begin
          next_hold = card_rdata_in;
          next_state = ST_REQ;
          next_req_n = 1'b0;
        end else begin
          done_xfer = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_REQ: if (!pci_gnt_n_in && pci_idle_in) begin
        next_req_n = 1'b1;
        next_start = 1'b1;
        next_mwrite = to_mem;
        next_state = ST_BUS;
      end
      ST_BUS: if (mst_done_in) begin
        if (to_mem) begin
          done_xfer = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_cwdata = mst_rdata_in;
          next_cyc = 1'b1;
          next_cwrite = 1'b1;
          next_cword = word_mode;
          next_we_tc = cur_count == 16'h0000;
          next_state = ST_CARD;
        end
      end
      ST_PCPCI: if (card_done_in) begin
        next_cyc = 1'b0;
        next_oe_tc = 1'b0;
        next_we_tc = 1'b0;
        next_io_ack = 1'b1;
        next_io_rdata = {16'h0000, card_rdata_in};
        next_pc_tc_done = pc_tc;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (done_xfer) begin
      next_cur_addr = cur_addr + (word_mode ? 32'h0000_0002 : 32'h0000_0001);
      if (cur_count == 16'h0000) begin
        next_status_tc = 1'b1;
        next_mask = 1'b1;
        next_card_dma_ack = 1'b0;
      end else begin
        next_cur_count = cur_count - 16'h0001;
      end
    end
    // slave registers answer in every engine state but ST_PCPCI; centralized cycles start only in ST_IDLE
    if (io_req && pc_hit) begin
      next_state = ST_PCPCI;
      next_cyc = 1'b1;
      next_cwrite = io_wr_in;
      next_cwdata = io_wdata_in[15:0];
      next_cword = chan_word;
      next_pc_tc = io_addr_in[2];
      next_oe_tc = io_addr_in[2] && io_rd_in;
      next_we_tc = io_addr_in[2] && io_wr_in;
    end else if (io_req && distributed_dma_hit && state != ST_PCPCI) begin
      next_io_ack = 1'b1;
      next_io_rdata = 32'h0000_0000;
      case (io_addr_in[3:0])
        DMA_ADDR: begin
          next_io_rdata = cur_addr;
          if (io_wr_in) begin
            next_base_addr = io_wdata_in;
            next_cur_addr = io_wdata_in;
          end
        end
        DMA_COUNT: begin
          next_io_rdata = {16'h0000, cur_count};
          if (io_wr_in) begin
            next_base_count = io_wdata_in[15:0];
            next_cur_count = io_wdata_in[15:0];
          end
        end
        DMA_STATUS: begin
          next_io_rdata[STAT_TC_BIT] = status_tc;
          next_io_rdata[STAT_REQ_BIT] = card_dma_request;
          if (io_wr_in && io_be_in[0]) next_cmd_dis = io_wdata_in[CMD_DISABLE_BIT];
          if (io_wr_in && io_be_in[2]) next_mode = io_wdata_in[16 + MODE_DIR_LSB +: 2];
          if (io_wr_in && io_be_in[1]) next_mask = 1'b0; // request also unmasks
        end
        DMA_MASK: begin
          next_io_rdata[0] = mask;
          if (io_wr_in && io_be_in[0]) next_mask = io_wdata_in[0];
          if (mclr) begin
            next_mask = MASK_RESET;
            next_cmd_dis = 1'b0;
            next_status_tc = 1'b0;
            next_state = ST_IDLE;
            next_req_n = 1'b1;
            next_start = 1'b0; // an abort never launches a memory cycle
            next_cyc = 1'b0;
            next_card_dma_ack = 1'b0;
            next_oe_tc = 1'b0;
            next_we_tc = 1'b0;
            if (state != ST_IDLE) begin
              next_status_tc = 1'b1;
              next_oe_tc = to_mem;
              next_we_tc = !to_mem;
            end
          end
        end
        default: next_io_rdata = 32'h0000_0000;
      endcase
    end else if (io_req) begin
      next_io_miss = 1'b1;
    end
    // terminal count wins over a mask or request write in the same cycle
    if (done_xfer && cur_count == 16'h0000) next_mask = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      base_addr <= 32'h0000_0000;
      cur_addr <= 32'h0000_0000;
      base_count <= 16'h0000;
      cur_count <= 16'h0000;
      hold <= 16'h0000;
      mode <= 2'h0;
      cmd_dis <= 1'b0;
      mask <= MASK_RESET;
      status_tc <= 1'b0;
      pc_tc <= 1'b0;
      pc_tc_done <= 1'b0;
      io_ack_out <= 1'b0;
      io_miss_out <= 1'b0;
      io_rdata_out <= 32'h0000_0000;
      pci_req_n_out <= 1'b1;
      mst_start_out <= 1'b0;
      mst_write_out <= 1'b0;
      card_cycle_out <= 1'b0;
      card_write_out <= 1'b0;
      card_word_out <= 1'b0;
      card_wdata_out <= 16'h0000;
      card_dma_ack_out <= 1'b0;
      card_oe_tc_out <= 1'b0;
      card_we_tc_out <= 1'b0;
    end else begin
      state <= next_state;
      base_addr <= next_base_addr;
      cur_addr <= next_cur_addr;
      base_count <= next_base_count;
      cur_count <= next_cur_count;
      hold <= next_hold;
      mode <= next_mode;
      cmd_dis <= next_cmd_dis;
      mask <= next_mask;
      status_tc <= next_status_tc;
      pc_tc <= next_pc_tc;
      pc_tc_done <= next_pc_tc_done;
      io_ack_out <= next_io_ack;
      io_miss_out <= next_io_miss;
      io_rdata_out <= next_io_rdata;
      pci_req_n_out <= next_req_n;
      mst_start_out <= next_start;
      mst_write_out <= next_mwrite;
      card_cycle_out <= next_cyc;
      card_write_out <= next_cwrite;
      card_word_out <= next_cword;
      card_wdata_out <= next_cwdata;
      card_dma_ack_out <= next_card_dma_ack;
      card_oe_tc_out <= next_oe_tc;
      card_we_tc_out <= next_we_tc;
    end
  end
  // master address and data follow the engine's own registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mst_addr_out <= 32'h0000_0000;
      mst_wdata_out <= 16'h0000;
    end else begin
      mst_addr_out <= next_cur_addr;
      mst_wdata_out <= next_hold;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_req_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == ST_REQ && pci_gnt_n_in && !mclr) |=> (state == ST_REQ && !pci_req_n_out))
    else $error("bus request dropped before grant");
  a_start_on_grant: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(mst_start_out) |-> !$past(pci_gnt_n_in) && $past(pci_idle_in) &&
    $past(state) == ST_REQ)
    else $error("master cycle started without idle grant");
  a_write_dir: assert property (@(posedge clk_in) disable iff (rst_in)
    mst_start_out |-> (mst_write_out == to_mem) ##1 (state == ST_BUS || $past(mclr)))
    else $error("master cycle direction wrong");
  a_ack_during: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == ST_CARD || state == ST_REQ || state == ST_BUS) |-> card_dma_ack_out)
    else $error("acknowledge dropped during transfer");
  a_abort_tc: assert property (@(posedge clk_in) disable iff (rst_in)
    (mclr && state != ST_IDLE && state != ST_PCPCI) |=> status_tc && !card_cycle_out &&
    (card_oe_tc_out || card_we_tc_out) && state == ST_IDLE)
    else $error("channel reset did not raise terminal count");
  a_io_answer: assert property (@(posedge clk_in) disable iff (rst_in)
    (io_req && distributed_dma_hit && !pc_hit && state != ST_PCPCI) |=> io_ack_out && !io_miss_out)
    else $error("slave register access not answered");
  a_tc_pin_dir: assert property (@(posedge clk_in) disable iff (rst_in)
    card_cycle_out |-> !(card_oe_tc_out && card_write_out) && !(card_we_tc_out && !card_write_out))
    else $error("terminal count on wrong card pin");
  a_pc_tc_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    pc_tc_done |=> !granted ##1 !card_cycle_out)
    else $error("grant survived terminal count cycle");
endmodule
`default_nettype wire

// >>> tb/pci_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pci_host_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pci_req_n_in,
  input wire logic mst_start_in,
  output logic pci_gnt_n_out,
  output logic pci_idle_out,
  output logic mst_done_out,
  output logic [15:0] mst_rdata_out
);
  logic [1:0] busy;
  assign pci_idle_out = 1'b1;
  // grant trails request by one cycle; a cycle ends three clocks after start
  // read data outside the done cycle inverts each clock, so after a done it matches again every other clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pci_gnt_n_out <= 1'b1;
      busy <= 2'h0;
      mst_done_out <= 1'b0;
      mst_rdata_out <= 16'h0000;
    end else begin
      pci_gnt_n_out <= pci_req_n_in;
      busy <= {busy[0], mst_start_in};
      mst_done_out <= busy[1];
      mst_rdata_out <= busy[1] ? 16'h5a3c : ~mst_rdata_out;
    end
  end
endmodule
`default_nettype wire

// >>> tb/card16_dma_slave_test.sv
`timescale 1ns/100ps
`default_nettype none
module card16_dma_slave_test;
  import card16_dma_pkg::*;
  logic clk_in = 0, rst_in = 1, cfg_rd = 0, cfg_wr = 0, io_rd = 0, io_wr = 0;
  logic cfg_ack, io_ack, io_miss, req_n, gnt_n, idle, mst_start, mst_write, mst_done;
  logic spk_n = 1, card_done = 0, cyc, cwr, cword, ack, oe_tc, we_tc, leg_req, grant_n = 1;
  logic [7:0] cfg_addr = 0;
  logic [15:0] io_addr = 0, mst_wdata, mst_rdata, card_wdata;
  logic [3:0] io_be = 0;
  logic [31:0] cfg_wdata = 0, io_wdata = 0, cfg_rdata, io_rdata, mst_addr, rd;
  int fails = 0, n_tests = 0;
  card16_dma_slave card16_dma_slave_i (.clk_in(clk_in), .rst_in(rst_in), .cfg_rd_in(cfg_rd),
    .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr), .cfg_wdata_in(cfg_wdata), .cfg_ack_out(cfg_ack),
    .cfg_rdata_out(cfg_rdata), .io_rd_in(io_rd), .io_wr_in(io_wr), .io_addr_in(io_addr),
    .io_be_in(io_be), .io_wdata_in(io_wdata), .io_ack_out(io_ack), .io_miss_out(io_miss),
    .io_rdata_out(io_rdata), .pci_req_n_out(req_n), .pci_gnt_n_in(gnt_n), .pci_idle_in(idle),
    .mst_start_out(mst_start), .mst_write_out(mst_write), .mst_addr_out(mst_addr),
    .mst_wdata_out(mst_wdata), .mst_done_in(mst_done), .mst_rdata_in(mst_rdata),
    .card_speaker_pin_n_in(spk_n), .card_io_width_pin_n_in(1'b1),
    .card_input_ack_pin_n_in(1'b1), .card_cycle_out(cyc), .card_write_out(cwr),
    .card_word_out(cword), .card_wdata_out(card_wdata), .card_done_in(card_done),
    .card_rdata_in(16'h00a5), .card_dma_ack_out(ack), .card_oe_tc_out(oe_tc),
    .card_we_tc_out(we_tc), .legacy_request_line_out(leg_req), .legacy_grant_line_n_in(grant_n));
  pci_host_model pci_host_model_i (.clk_in(clk_in), .rst_in(rst_in), .pci_req_n_in(req_n),
    .mst_start_in(mst_start), .pci_gnt_n_out(gnt_n), .pci_idle_out(idle),
    .mst_done_out(mst_done), .mst_rdata_out(mst_rdata));
  // ---------------------------------------------------------------
  // card finishes each cycle one clock after it is asked
  // ---------------------------------------------------------------
  always @(posedge clk_in) card_done <= cyc & ~card_done;
  initial forever #5 clk_in = ~clk_in;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in) #1;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {wr, !wr, a, d};
    @(posedge clk_in) #1;
    {cfg_wr, cfg_rd} = 2'b00;
    rd = cfg_rdata;
    check("cfg ack", 1, cfg_ack);
  endtask
  // strobe is a one-cycle pulse; answer lands one clock after it is taken
  task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be,
                    input logic [31:0] d, input logic miss);
    @(posedge clk_in) #1;
    {io_wr, io_rd, io_addr, io_be, io_wdata} = {wr, !wr, a, be, d};
    @(posedge clk_in) #1;
    {io_wr, io_rd} = 2'b00;
    rd = io_rdata;
    check("io miss", miss, io_miss);
    check("io ack", !miss, io_ack);
  endtask
  task automatic t_config();
    cfg(0, CFG_SYS_CTRL, 0);
    check("system control", 32'h0000_0008, rd);
    cfg(0, 8'h40, 0);
    check("unmapped cfg", 0, rd);
    cfg(1, CFG_SOCK_DMA0, 32'h0000_0001);
    cfg(1, CFG_SOCK_DMA1, 32'h0000_0100);
    cfg(0, CFG_SOCK_DMA1, 0);
    check("dma config 1", 32'h0000_0100, rd);
    $display("config test done");
  endtask
  task automatic t_regs();
    io(1, 16'h0100, 4'hf, 32'h0000_1000, 0);
    io(1, 16'h0104, 4'hf, 32'h0000_0001, 0);
    io(1, 16'h0108, 4'h4, 32'h0004_0000, 0);
    io(1, 16'h010c, 4'h1, 0, 0);
    io(0, 16'h0100, 4'hf, 0, 0);
    check("current address", 32'h0000_1000, rd);
    io(0, 16'h010c, 4'hf, 0, 0);
    check("mask reg", 0, rd);
    io(0, 16'h0200, 4'hf, 0, 1);
    $display("register test done");
  endtask
  // two byte transfers to memory, count of one, then terminal count
  task automatic t_dma();
    int i, k;
    spk_n = 0;
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 100 && mst_start !== 1'b1; i++) @(posedge clk_in) #1;
      check("mst start", 1, mst_start);
      check("mst addr", 32'h1000 + k, mst_addr);
      check("mst write", 1, mst_write);
      check("mst data", 8'ha5, mst_wdata[7:0]);
      check("card ack", 1, ack);
      @(posedge clk_in) #1;
    end
    repeat (4) @(posedge clk_in) #1;
    check("ack after tc", 0, ack);
    io(0, 16'h0108, 4'hf, 0, 0);
    check("status tc", 1, rd[0]);
    spk_n = 1;
    $display("transfer test done");
  endtask
  // byte to the card at count zero, then master clear while requesting
  task automatic t_card();
    int i;
    io(1, 16'h0108, 4'h4, 32'h0008_0000, 0);
    spk_n = 0;
    io(1, 16'h010c, 4'h1, 0, 0);
    for (i = 0; i < 99 && cyc !== 1'b1; i++) @(posedge clk_in) #1;
    check("card write", 1, cwr);
    check("card data", 8'h3c, card_wdata[7:0]);
    check("we tc", 1, we_tc);
    repeat (4) @(posedge clk_in) #1;
    io(0, 16'h0108, 4'hf, 0, 0);
    check("card status tc", 1, rd[0]);
    io(1, 16'h010c, 4'h1, 0, 0);
    @(posedge clk_in) #1;
    check("bus request", 0, req_n);
    io(1, 16'h010c, 4'h2, 0, 0);
    check("abort tc pin", 1, we_tc);
    check("abort ack", 0, ack);
    io(0, 16'h0108, 4'hf, 0, 0);
    check("abort status", 1, rd[0]);
    $display("card test done");
  endtask
  // channel 1 bytes: request frame out, grant frame in, then a tc read
  task automatic t_pcpci();
    int i;
    logic [3:0] bits;
    logic [5:0] gf = 6'h26;
    cfg(1, CFG_SYS_CTRL, 32'h0009_0008);
    for (i = 0; i < 9 && leg_req !== 1'b0; i++) @(posedge clk_in) #1;
    for (i = 0; i < 10; i++) begin
      @(posedge clk_in) #1;
      if (i < 4) bits[i] = leg_req;
      else grant_n = gf[i - 4];
    end
    check("request frame", 4'h3, bits);
    repeat (3) @(posedge clk_in) #1;
    {io_rd, io_addr} = {1'b1, PC_NORMAL_TC};
    @(posedge clk_in) #1;
    io_rd = 0;
    check("pc oe tc", 1, oe_tc);
    check("pc word", 0, cword);
    for (i = 0; i < 9 && io_ack !== 1'b1; i++) @(posedge clk_in) #1;
    check("pc data", 8'ha5, io_rdata);
    io(0, 16'h0000, 4'hf, 0, 1);
    spk_n = 1;
    $display("centralized test done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    #1 rst_in = 0;
    t_config();
    t_regs();
    t_dma();
    t_card();
    t_pcpci();
    finish_test();
  end
endmodule
`default_nettype wire
